// ==== verilog/block_packet_encapsulator.sv ====
// Block encapsulator: packet words to 65-bit blocks and back
`timescale 1ns/1ps
module block_packet_encapsulator #(
  parameter int FRAME_BITS = 8224
) (
  input  wire logic                      ref_clk_i,   // 200 MHz clock
  input  wire logic                      sys_rst_i,   // Async reset, high
  input  wire blk_encap_pkg::tx_word_t   in_word_i,   // Packet word from source
  input  wire logic                      in_valid_i,  // Source word valid
  output logic                           in_ready_o,  // Word accepted when high
  output logic [64:0]                    tx_block_o,  // Current outgoing block
  input  wire logic                      tx_take_i,   // Sink consumes block
  output logic [13:0]                    next_ptr_o,  // First block start next frame
  input  wire logic [64:0]               rx_block_i,  // Received block
  input  wire logic                      rx_valid_i,  // Received block valid
  output blk_encap_pkg::rx_word_t        rx_word_o,   // De-encapsulated word
  output logic                           rx_valid_o,  // Word valid pulse
  output logic                           rx_drop_o    // Bad control block pulse
);
  // ==========================================================
  // State
  typedef struct packed {
    blk_encap_pkg::tx_st_t   st;
    blk_encap_pkg::tx_word_t hold;
    logic                    hold_v;
    logic                    in_rdy;
    logic                    b2b;
    logic [7:0]              pcrc;
    logic [64:0]             blk;
    logic                    last_blk;
    logic                    prev_end;
    logic [5:0]              prev_eo;
    logic [13:0]             pos;
    logic [13:0]             ptr;
    logic                    rx_pend_s;
    logic                    rx_skip;
    logic                    rx_pend_e;
    logic                    rx_in;
    logic [6:0]              rx_so;
    logic [5:0]              rx_eo;
    logic [7:0]              rx_exp;
    logic [7:0]              rx_crc;
    blk_encap_pkg::rx_word_t rxw;
    logic                    rx_v;
    logic                    rx_drop;
  } state_t;

  localparam state_t RST_STATE = '{st: blk_encap_pkg::ST_IDLE,
                                   blk: blk_encap_pkg::IDLE_BLK, default: '0};
  localparam logic [13:0] FRAME_LEN = 14'(FRAME_BITS);
  localparam logic [13:0] BLK_LEN   = 14'(blk_encap_pkg::BLK_W);

  state_t r;
  state_t next_r;

  function automatic logic [63:0] keep_mask(logic [6:0] n);
    for (int j = 0; j < blk_encap_pkg::DATA_W; j++) keep_mask[j] = (j < int'(n));
  endfunction : keep_mask

  // ==========================================================
  // Next state
  always_comb begin
    blk_encap_pkg::ctrl_t c;
    logic [13:0]          npos;
    logic                 st_here;
    logic [5:0]           lo;
    logic [5:0]           hi;
    logic [7:0]           crc;
    logic [63:0]          rxd;
    c       = '0;
    npos    = '0;
    st_here = 1'b0;
    lo      = '0;
    hi      = '0;
    crc     = '0;
    rxd     = rx_block_i[blk_encap_pkg::BLK_W-1:1];
    next_r  = r;
    next_r.rx_v    = 1'b0;
    next_r.rx_drop = 1'b0;
    c.proto = blk_encap_pkg::PROTO_ETH;

    if (tx_take_i) begin
      next_r.prev_end = r.blk[blk_encap_pkg::TYPE_POS] & r.blk[blk_encap_pkg::EF_POS];
      next_r.prev_eo  = r.blk[blk_encap_pkg::EO_POS +: 6];
      next_r.last_blk = 1'b0;
      // Block start positions walk through the frame
      npos = r.pos + BLK_LEN;
      if (npos >= FRAME_LEN) begin
        npos       = npos - FRAME_LEN;
        next_r.ptr = npos;
      end
      next_r.pos = npos;
      case (r.st)
        blk_encap_pkg::ST_IDLE: begin
          if (r.hold_v && r.hold.sop) begin
            c.sf = 1'b1;
            c.so = '0;
            c.lf = r.hold.len_flag;
            c.lv = r.hold.len;
            if (r.hold.eop) begin
              // Short packet: start and end in one control block
              c.ef   = 1'b1;
              c.eo   = 6'(r.hold.nbits - blk_encap_pkg::ONE_BIT);
              c.pcrc = blk_encap_pkg::crc_span(8'h00, r.hold.data, 0,
                         int'(r.hold.nbits) - 1, blk_encap_pkg::PCRC_POLY);
              next_r.st = blk_encap_pkg::ST_TAIL;
            end else begin
              next_r.st = blk_encap_pkg::ST_BODY;
            end
            next_r.blk  = blk_encap_pkg::mk_ctrl(c);
            next_r.pcrc = 8'h00;
          end else begin
            next_r.blk = blk_encap_pkg::IDLE_BLK;
            // A stray word without start is discarded
            if (r.hold_v) next_r.hold_v = 1'b0;
          end
        end
        blk_encap_pkg::ST_BODY: begin
          if (!r.hold_v) begin
            // Underrun inside a packet: pad keeps blocks flowing
            next_r.blk = blk_encap_pkg::PAD_BLK;
          end else if (r.hold.eop) begin
            c.ef   = 1'b1;
            c.eo   = 6'(r.hold.nbits - blk_encap_pkg::ONE_BIT);
            c.pcrc = blk_encap_pkg::crc_span(r.pcrc, r.hold.data, 0,
                       int'(r.hold.nbits) - 1, blk_encap_pkg::PCRC_POLY);
            // Next start already waiting: announce it two data blocks ahead
            if (in_valid_i && in_word_i.sop) begin
              c.sf = 1'b1;
              c.so = blk_encap_pkg::SO_SKIP;
              c.lf = in_word_i.len_flag;
              c.lv = in_word_i.len;
            end
            next_r.b2b = in_valid_i & in_word_i.sop;
            next_r.blk = blk_encap_pkg::mk_ctrl(c);
            next_r.st  = blk_encap_pkg::ST_TAIL;
          end else begin
            next_r.blk    = {r.hold.data, 1'b0};
            next_r.pcrc   = blk_encap_pkg::crc_span(r.pcrc, r.hold.data, 0,
                              blk_encap_pkg::DATA_W - 1, blk_encap_pkg::PCRC_POLY);
            next_r.hold_v = 1'b0;
          end
        end
        blk_encap_pkg::ST_TAIL: begin
          // Bits past the packet end are forced to zero
          next_r.blk      = {r.hold.data & keep_mask(r.hold.nbits), 1'b0};
          next_r.hold_v   = 1'b0;
          next_r.last_blk = 1'b1;
          next_r.pcrc     = 8'h00;
          next_r.b2b      = 1'b0;
          next_r.st       = r.b2b ? blk_encap_pkg::ST_BODY : blk_encap_pkg::ST_IDLE;
        end
        default: begin
          next_r.st  = blk_encap_pkg::ST_IDLE;
          next_r.blk = blk_encap_pkg::IDLE_BLK;
        end
      endcase
    end

    // Load only into an empty holding slot; never collides with a take
    if (in_valid_i && r.in_rdy) begin
      next_r.hold   = in_word_i;
      next_r.hold_v = 1'b1;
    end
    next_r.in_rdy = !next_r.hold_v;

    // ==========================================================
    // Receive path
    if (rx_valid_i) begin
      if (rx_block_i[blk_encap_pkg::TYPE_POS]) begin
        if (blk_encap_pkg::control_crc_of(rx_block_i) !=
            blk_encap_pkg::rev8(rx_block_i[blk_encap_pkg::CONTROL_CRC_POS +: 8])) begin
          next_r.rx_drop = 1'b1;
        end else begin
          if (rx_block_i[blk_encap_pkg::EF_POS]) begin
            next_r.rx_pend_e = 1'b1;
            next_r.rx_eo     = rx_block_i[blk_encap_pkg::EO_POS +: 6];
            next_r.rx_exp    = blk_encap_pkg::rev8(rx_block_i[blk_encap_pkg::PCRC_POS +: 8]);
          end
          if (rx_block_i[blk_encap_pkg::SF_POS]) begin
            next_r.rx_pend_s = 1'b1;
            next_r.rx_so     = rx_block_i[blk_encap_pkg::SO_POS +: 7];
            next_r.rx_skip   = (rx_block_i[blk_encap_pkg::SO_POS +: 7] ==
                                blk_encap_pkg::SO_SKIP);
          end
        end
      end else begin
        // Limitation: an end and a non-deferred start in one block are not split
        st_here = r.rx_pend_s && !r.rx_skip;
        lo      = st_here ? r.rx_so[5:0] : 6'h00;
        hi      = r.rx_pend_e ? r.rx_eo : blk_encap_pkg::OFF_LAST;
        if (r.rx_in || st_here) begin
          crc = blk_encap_pkg::crc_span(st_here ? 8'h00 : r.rx_crc, rxd, int'(lo), int'(hi),
                                        blk_encap_pkg::PCRC_POLY);
          next_r.rx_crc    = crc;
          next_r.rxw.data  = rxd;
          next_r.rxw.first = lo;
          next_r.rxw.last  = hi;
          next_r.rxw.sop   = st_here;
          next_r.rxw.eop   = r.rx_pend_e;
          next_r.rxw.err   = r.rx_pend_e && (crc != r.rx_exp);
          next_r.rx_v      = 1'b1;
          next_r.rx_in     = !r.rx_pend_e;
        end
        next_r.rx_pend_e = 1'b0;
        next_r.rx_skip   = 1'b0;
        if (st_here) next_r.rx_pend_s = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= RST_STATE;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready_o = r.in_rdy;
  assign tx_block_o = r.blk;
  assign next_ptr_o = r.ptr;
  assign rx_word_o  = r.rxw;
  assign rx_valid_o = r.rx_v;
  assign rx_drop_o  = r.rx_drop;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_IDLE_FILL: assert property (
    (r.st == blk_encap_pkg::ST_IDLE && !r.hold_v && tx_take_i)
      |=> tx_block_o == blk_encap_pkg::IDLE_BLK)
    else $error("idle block not sent when empty");

  AST_PAD_GAP: assert property (
    (r.st == blk_encap_pkg::ST_BODY && !r.hold_v && tx_take_i)
      |=> tx_block_o == blk_encap_pkg::PAD_BLK)
    else $error("pad block not sent on underrun");

  AST_END_FIRST: assert property (
    r.last_blk |-> r.prev_end && !tx_block_o[blk_encap_pkg::TYPE_POS])
    else $error("final data block without preceding end control");

  AST_ZERO_TAIL: assert property (
    r.last_blk |-> (tx_block_o[64:1] & ~keep_mask(7'(r.prev_eo) + 7'h01)) == 64'h0)
    else $error("bits after packet end not zero");

  AST_CTRL_CRC: assert property (
    tx_block_o[blk_encap_pkg::TYPE_POS]
      |-> blk_encap_pkg::rev8(tx_block_o[blk_encap_pkg::CONTROL_CRC_POS +: 8]) ==
          blk_encap_pkg::control_crc_of(tx_block_o))
    else $error("control CRC wrong");

  AST_B2B_SKIP: assert property (
    (tx_block_o[blk_encap_pkg::TYPE_POS] && tx_block_o[blk_encap_pkg::EF_POS] &&
     tx_block_o[blk_encap_pkg::SF_POS] && !r.last_blk && r.st == blk_encap_pkg::ST_TAIL &&
     r.b2b) |-> tx_block_o[blk_encap_pkg::SO_POS +: 7] == blk_encap_pkg::SO_SKIP)
    else $error("back-to-back start offset not deferred");

  AST_PROTO_USE: assert property (
    (tx_block_o[blk_encap_pkg::TYPE_POS] && tx_block_o[blk_encap_pkg::SF_POS])
      |-> tx_block_o[blk_encap_pkg::PROTO_POS +: 8] == blk_encap_pkg::PROTO_ETH &&
          tx_block_o[blk_encap_pkg::PS_POS +: 7] == 7'h00)
    else $error("reserved protocol value used");

  AST_PTR_STEP: assert property (
    (tx_take_i && r.pos + BLK_LEN >= FRAME_LEN)
      |=> next_ptr_o == $past(r.pos) + BLK_LEN - FRAME_LEN && next_ptr_o < FRAME_LEN)
    else $error("next block pointer wrong");

  AST_RX_DROP: assert property (
    (rx_valid_i && rx_block_i[blk_encap_pkg::TYPE_POS] &&
     blk_encap_pkg::control_crc_of(rx_block_i) !=
     blk_encap_pkg::rev8(rx_block_i[blk_encap_pkg::CONTROL_CRC_POS +: 8]))
      |=> rx_drop_o && !rx_valid_o)
    else $error("bad control block not dropped");

  AST_RX_ERR_EOP: assert property (
    (rx_valid_o && rx_word_o.err) |-> rx_word_o.eop)
    else $error("packet error flagged off the end word");

  AST_START_CTRL: assert property (
    (r.st == blk_encap_pkg::ST_IDLE && r.hold_v && r.hold.sop && tx_take_i)
      |=> tx_block_o[blk_encap_pkg::TYPE_POS] && tx_block_o[blk_encap_pkg::SF_POS] &&
          tx_block_o[blk_encap_pkg::SO_POS +: 7] == 7'h00)
    else $error("start control missing before packet");

  AST_DATA_COPY: assert property (
    (r.st == blk_encap_pkg::ST_BODY && r.hold_v && !r.hold.eop && tx_take_i)
      |=> !tx_block_o[blk_encap_pkg::TYPE_POS] && tx_block_o[64:1] == $past(r.hold.data))
    else $error("data block does not carry the held word");

  AST_TAIL_DATA: assert property (
    (r.st == blk_encap_pkg::ST_TAIL && tx_take_i)
      |=> !tx_block_o[blk_encap_pkg::TYPE_POS] && r.last_blk)
    else $error("final data block not sent after end control");

  COV_SHORT: cover property (r.st == blk_encap_pkg::ST_IDLE && r.hold_v && r.hold.eop &&
                             tx_take_i);
  COV_B2B: cover property (r.st == blk_encap_pkg::ST_TAIL && r.b2b && tx_take_i);
  COV_PAD: cover property (tx_block_o == blk_encap_pkg::PAD_BLK);
  COV_RX_ERR: cover property (rx_valid_o && rx_word_o.err);
  COV_RX_DROP: cover property (rx_drop_o);
endmodule : block_packet_encapsulator

// ==== verilog/blk_encap_pkg.sv ====
// Constants, carriers and CRC helpers for the 65-bit block encapsulator
package blk_encap_pkg;
  // ==========================================================
  // Block layout
  localparam int BLK_W     = 65;
  localparam int DATA_W    = 64;
  localparam int TYPE_POS  = 0;
  localparam int EF_POS    = 1;
  localparam int EO_POS    = 2;
  localparam int PCRC_POS  = 8;
  localparam int SF_POS    = 16;
  localparam int SO_POS    = 17;
  localparam int PROTO_POS = 24;
  localparam int LF_POS    = 32;
  localparam int LV_POS    = 33;
  localparam int PS_POS    = 50;
  localparam int CONTROL_CRC_HI   = 56;
  localparam int CONTROL_CRC_POS  = 57;
  localparam logic [7:0] CONTROL_CRC_POLY  = 8'h63;
  localparam logic [7:0] PCRC_POLY  = 8'h9B;
  localparam logic [7:0] PROTO_IDLE = 8'h00;
  localparam logic [7:0] PROTO_ETH  = 8'h01;
  localparam logic [7:0] PROTO_PAD  = 8'hFF;
  localparam logic [7:0] IDLE_CONTROL_CRC  = 8'h87;
  localparam logic [7:0] PAD_CONTROL_CRC   = 8'h90;
  localparam logic [6:0] SO_SKIP    = 7'h40;
  localparam logic [5:0] OFF_LAST   = 6'h3F;
  localparam logic [6:0] ONE_BIT    = 7'h01;

  // ==========================================================
  // Carriers
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BODY = 2'b01, ST_TAIL = 2'b11} tx_st_t;
  typedef struct packed {
    logic [63:0] data;     // Bit 0 is the first packet bit
    logic [6:0]  nbits;    // Valid bits 1..64, read on eop word
    logic        sop;
    logic        eop;
    logic        len_flag;
    logic [16:0] len;
  } tx_word_t;
  typedef struct packed {
    logic [63:0] data;
    logic [5:0]  first;
    logic [5:0]  last;
    logic        sop;
    logic        eop;
    logic        err;
  } rx_word_t;
  typedef struct packed {
    logic        ef;
    logic [5:0]  eo;
    logic [7:0]  pcrc;
    logic        sf;
    logic [6:0]  so;
    logic [7:0]  proto;
    logic        lf;
    logic [16:0] lv;
  } ctrl_t;

  // ==========================================================
  // CRC helpers; serial Galois form, register S7..S0
  function automatic logic [7:0] crc_step(logic [7:0] s, logic d, logic [7:0] poly);
    crc_step = {s[6:0], 1'b0} ^ ((d ^ s[7]) ? poly : 8'h00);
  endfunction : crc_step

  function automatic logic [7:0] crc_span(logic [7:0] s, logic [63:0] d, int lo, int hi,
                                          logic [7:0] poly);
    logic [7:0] c;
    c = s;
    for (int j = 0; j < DATA_W; j++) begin
      if (j >= lo && j <= hi) c = crc_step(c, d[j], poly);
    end
    crc_span = c;
  endfunction : crc_span

  // S7 goes on the wire first, so it lands at the lowest field bit
  function automatic logic [7:0] rev8(logic [7:0] v);
    for (int j = 0; j < 8; j++) rev8[j] = v[7-j];
  endfunction : rev8

  function automatic logic [7:0] control_crc_of(logic [BLK_W-1:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int j = 0; j <= CONTROL_CRC_HI; j++) c = crc_step(c, b[j], CONTROL_CRC_POLY);
    control_crc_of = c;
  endfunction : control_crc_of

  function automatic logic [BLK_W-1:0] mk_ctrl(ctrl_t c);
    logic [BLK_W-1:0] b;
    b = '0;
    b[TYPE_POS]       = 1'b1;
    b[EF_POS]         = c.ef;
    b[EO_POS +: 6]    = c.eo;
    b[PCRC_POS +: 8]  = rev8(c.pcrc);
    b[SF_POS]         = c.sf;
    b[SO_POS +: 7]    = c.so;
    b[PROTO_POS +: 8] = c.proto;
    b[LF_POS]         = c.lf;
    b[LV_POS +: 17]   = c.lv;
    b[CONTROL_CRC_POS +: 8]  = rev8(control_crc_of(b));
    mk_ctrl = b;
  endfunction : mk_ctrl

  // Fixed check values already sit in field order, S7 at the lowest bit
  localparam logic [BLK_W-1:0] IDLE_BLK = {IDLE_CONTROL_CRC, 56'h0, 1'b1};
  localparam logic [BLK_W-1:0] PAD_BLK  = {PAD_CONTROL_CRC, 25'h0, PROTO_PAD, 23'h0, 1'b1};
endpackage : blk_encap_pkg

// ==== dv/mac_partner.sv ====
// Source and sink model of the packet interface partner
`timescale 1ns/1ps
module mac_partner (
  input  wire logic               clk_i,   // Clock
  input  wire logic               rst_i,   // Reset, high
  input  wire logic               ready_i, // Encapsulator ready
  output blk_encap_pkg::tx_word_t word_o,  // Word offered
  output logic                    valid_o, // Word valid
  output logic                    take_o   // Sink takes a block
);
  blk_encap_pkg::tx_word_t wq[$];
  int                      gq[$];
  int                      gap;
  task automatic push(input blk_encap_pkg::tx_word_t w, input int g);
    wq.push_back(w);
    gq.push_back(g);
  endtask : push
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      take_o  <= 1'b0;
      word_o  <= '0;
      gap     <= 0;
    end else begin
      // Sink skips one take after an end word so a queued start is seen at end control
      take_o <= !(valid_o && ready_i && word_o.eop);
      if (valid_o && ready_i) begin
        valid_o <= 1'b0;
        // Released bus is driven inverted so it never repeats the accepted word
        word_o  <= ~word_o;
      end else if (!valid_o && wq.size() > 0) begin
        if (gap < gq[0]) begin
          gap <= gap + 1;
        end else begin
          word_o  <= wq.pop_front();
          void'(gq.pop_front());
          valid_o <= 1'b1;
          gap     <= 0;
        end
      end
    end
  end
endmodule : mac_partner

// ==== dv/testbench.sv ====
// Self-checking bench for the block encapsulator
`timescale 1ns/1ps
module testbench;
  localparam int         FB = 200;
  localparam logic [7:0] PP = blk_encap_pkg::PCRC_POLY;
  localparam logic [7:0] CP = blk_encap_pkg::CONTROL_CRC_POLY;
  logic                    ref_clk_i, sys_rst_i, in_valid_i, in_ready_o, tx_take_i;
  logic                    rx_valid_i, rx_valid_o, rx_drop_o, inject, ptr_pend;
  blk_encap_pkg::tx_word_t in_word_i;
  blk_encap_pkg::rx_word_t rx_word_o;
  blk_encap_pkg::rx_word_t rx_q[$];
  logic [64:0]             tx_block_o, rx_block_i;
  logic [64:0]             blk_q[$], exp_q[$];
  logic [13:0]             next_ptr_o, exp_ptr;
  int                      error_cnt, check_count, pos;

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  block_packet_encapsulator #(.FRAME_BITS(FB)) dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .in_word_i(in_word_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .tx_block_o(tx_block_o),
    .tx_take_i(tx_take_i), .next_ptr_o(next_ptr_o), .rx_block_i(rx_block_i),
    .rx_valid_i(rx_valid_i), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o),
    .rx_drop_o(rx_drop_o));
  mac_partner partner (
    .clk_i(ref_clk_i), .rst_i(sys_rst_i), .ready_i(in_ready_o), .word_o(in_word_i),
    .valid_o(in_valid_i), .take_o(tx_take_i));

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] crc(logic [7:0] s, logic [63:0] d, int n, logic [7:0] p);
    for (int j = 0; j < n; j++) s = {s[6:0], 1'b0} ^ ((d[j] ^ s[7]) ? p : 8'h00);
    return s;
  endfunction : crc

  function automatic logic [7:0] rv(logic [7:0] v);
    for (int j = 0; j < 8; j++) rv[j] = v[7-j];
  endfunction : rv

  function automatic logic [64:0] ctl(logic ef, logic [5:0] eo, logic [7:0] pc, logic sf,
      logic [6:0] so, logic [7:0] pr, logic lf, logic [16:0] lv, logic fix, logic [7:0] fc);
    logic [64:0] b;
    b = {15'h0000, lv, lf, pr, so, sf, rv(pc), eo, ef, 1'b1};
    b[64:57] = fix ? fc : rv(crc(8'h00, 64'(b[56:0]), 57, CP));
    return b;
  endfunction : ctl

  function automatic logic [64:0] dat(logic [63:0] d, int n);
    return {d & ((n >= 64) ? '1 : ((64'h1 << n) - 1)), 1'b0};
  endfunction : dat

  function automatic blk_encap_pkg::tx_word_t w(logic [63:0] d, logic [6:0] n, logic s,
      logic e, logic lf, logic [16:0] l);
    return '{data: d, nbits: n, sop: s, eop: e, len_flag: lf, len: l};
  endfunction : w

  // Loopback of the outgoing stream into the receiver unless a test injects blocks
  always @(posedge ref_clk_i) begin
    if (!inject) begin
      rx_block_i <= tx_block_o;
      rx_valid_i <= tx_take_i;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!sys_rst_i) begin
      if (ptr_pend) chk(next_ptr_o === exp_ptr, "frame pointer");
      ptr_pend <= 1'b0;
      if (tx_take_i) begin
        blk_q.push_back(tx_block_o);
        pos <= (pos + 65 >= FB) ? pos + 65 - FB : pos + 65;
        ptr_pend <= (pos + 65 >= FB);
        exp_ptr <= 14'(pos + 65 - FB);
      end
      if (rx_valid_o) rx_q.push_back(rx_word_o);
    end
  end

  task automatic start();
    blk_q.delete();
    rx_q.delete();
    exp_q.delete();
  endtask : start

  // Waits for the packet to pass, drops idles, counts pads, compares the rest
  task automatic run_check(input int min_pads, input logic [5:0] last);
    logic [64:0] idle, pad, fil[$];
    int          pads, tail, seen;
    idle = ctl(0, 0, 0, 0, 0, 8'h00, 0, 0, 1, 8'h87);
    pad = ctl(0, 0, 0, 0, 0, 8'hFF, 0, 0, 1, 8'h90);
    pads = 0;
    tail = 0;
    seen = 0;
    for (int i = 0; i < 400 && !(seen && tail >= 4); i++) begin
      @(posedge ref_clk_i);
      #1;
      if (blk_q.size() > 0 && blk_q[$] !== idle) begin
        seen = 1;
        tail = 0;
      end else if (seen) tail++;
    end
    foreach (blk_q[i]) begin
      if (blk_q[i] === pad) pads++;
      else if (blk_q[i] !== idle) fil.push_back(blk_q[i]);
    end
    chk(pads >= min_pads, "pad count");
    chk(fil.size() == exp_q.size(), "block count");
    foreach (exp_q[i]) if (i < fil.size()) chk(fil[i] === exp_q[i], "block content");
    chk(rx_q.size() > 0 && rx_q[0].sop === 1'b1 && rx_q[0].first === 6'h00, "rx start");
    chk(rx_q.size() > 0 && rx_q[$].eop === 1'b1 && rx_q[$].last === last
        && rx_q[$].err === 1'b0, "rx end");
  endtask : run_check

  task automatic t_idle();
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk(tx_block_o === ctl(0, 0, 0, 0, 0, 8'h00, 0, 0, 1, 8'h87), "idle block");
    chk(in_ready_o === 1'b1, "ready after reset");
    $display("t_idle done");
  endtask : t_idle

  task automatic t_short();
    logic [63:0] d;
    d = 64'hFFFF_F000_000A_BCDE;
    start();
    partner.push(w(d, 7'd20, 1, 1, 1, 17'd20), 0);
    exp_q.push_back(ctl(1, 19, crc(0, d, 20, PP), 1, 0, 8'h01, 1, 20, 0, 0));
    exp_q.push_back(dat(d, 20));
    run_check(0, 6'd19);
    $display("t_short done");
  endtask : t_short

  task automatic t_pad();
    logic [63:0] d0, d1, d2;
    d0 = 64'h0123_4567_89AB_CDEF;
    d1 = 64'hFEDC_BA98_7654_3210;
    d2 = 64'h5A5A_5A5A_5A5A_5AA5;
    start();
    partner.push(w(d0, 7'd64, 1, 0, 1, 17'd136), 0);
    partner.push(w(d1, 7'd64, 0, 0, 0, 17'd0), 8);
    partner.push(w(d2, 7'd8, 0, 1, 0, 17'd0), 0);
    exp_q.push_back(ctl(0, 0, 0, 1, 0, 8'h01, 1, 136, 0, 0));
    exp_q.push_back(dat(d0, 64));
    exp_q.push_back(dat(d1, 64));
    exp_q.push_back(ctl(1, 7, crc(crc(crc(0, d0, 64, PP), d1, 64, PP), d2, 8, PP),
                        0, 0, 8'h01, 0, 0, 0, 0));
    exp_q.push_back(dat(d2, 8));
    run_check(1, 6'd7);
    $display("t_pad done");
  endtask : t_pad

  task automatic t_b2b();
    logic [63:0] a0, a1, b0, b1;
    a0 = 64'h1111_2222_3333_4444;
    a1 = 64'h8000_0000_0000_0001;
    b0 = 64'hDEAD_BEEF_0BAD_F00D;
    b1 = 64'hF0F0_0000_0000_0ABC;
    start();
    partner.push(w(a0, 7'd64, 1, 0, 1, 17'd128), 0);
    partner.push(w(a1, 7'd64, 0, 1, 0, 17'd0), 0);
    partner.push(w(b0, 7'd64, 1, 0, 1, 17'd76), 0);
    partner.push(w(b1, 7'd12, 0, 1, 0, 17'd0), 0);
    exp_q.push_back(ctl(0, 0, 0, 1, 0, 8'h01, 1, 128, 0, 0));
    exp_q.push_back(dat(a0, 64));
    exp_q.push_back(ctl(1, 63, crc(crc(0, a0, 64, PP), a1, 64, PP), 1, 7'h40,
                        8'h01, 1, 76, 0, 0));
    exp_q.push_back(dat(a1, 64));
    exp_q.push_back(dat(b0, 64));
    exp_q.push_back(ctl(1, 11, crc(crc(0, b0, 64, PP), b1, 12, PP), 0, 0, 8'h01, 0, 0, 0, 0));
    exp_q.push_back(dat(b1, 12));
    run_check(0, 6'd11);
    $display("t_b2b done");
  endtask : t_b2b

  task automatic rx_send(input logic [64:0] b, input logic drop, input logic vld);
    @(posedge ref_clk_i);
    rx_block_i <= b;
    rx_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
    rx_block_i <= ~b;
    #1;
    chk(rx_drop_o === drop && rx_valid_o === vld, "rx pulse");
  endtask : rx_send

  task automatic t_rx();
    logic [63:0] d;
    d = 64'h0000_0000_0000_00C3;
    @(posedge ref_clk_i);
    #1;
    inject = 1'b1;
    rx_send(ctl(0, 0, 0, 1, 0, 8'h01, 0, 0, 0, 0) ^ {1'b1, 64'h0}, 1, 0);
    rx_send(ctl(1, 7, ~crc(0, d, 8, PP), 1, 0, 8'h01, 0, 0, 0, 0), 0, 0);
    rx_send({d, 1'b0}, 0, 1);
    chk(rx_word_o.err === 1'b1 && rx_word_o.sop === 1'b1 && rx_word_o.eop === 1'b1
        && rx_word_o.last === 6'd7, "rx crc error");
    inject = 1'b0;
    $display("t_rx done");
  endtask : t_rx

  initial begin
    sys_rst_i = 1'b1;
    inject = 1'b0;
    rx_block_i = '0;
    rx_valid_i = 1'b0;
    ptr_pend = 1'b0;
    exp_ptr = '0;
    pos = 0;
    error_cnt = 0;
    check_count = 0;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_idle();
    t_short();
    t_pad();
    t_b2b();
    t_rx();
    stop_test();
  end

  // Whole run needs at most about 1200 cycles
  initial begin
    #50000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : testbench
